// ===== verif/pio_pad_model.sv
module pio_pad_model
   import pio_port_pkg::*;
(
   input  wire pad_drive_type d,
   input  wire logic [31:0]   xv,
   input  wire logic [31:0]   xe,
   output logic [31:0]        pad
);
   timeunit 1ns;
   timeprecision 1ns;
   // undriven lines read their pull_up bit, low where there is no pull-up; never hold the last value
   assign pad = d.oe & d.out | ~d.oe & (xe & xv | ~xe & d.pull_up);
endmodule // pio_pad_model

// ===== verif/programmable_io_port_sva.sv
module programmable_io_port_sva
   import pio_port_pkg::*;
(
   input wire logic          CLK_SYS, RST_N, MODE_WE, PIN_WE, STATUS_RE, STATUS_SEL,
   input wire logic          STATUS_VALID,
   input wire mode_cmd_type  MODE_CMD,
   input wire logic [15:0]   STATUS_DATA,
   input wire logic [31:0]   ALT_OE, PAD_IN,
   input wire pad_drive_type PAD_DRIVE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   wire pad_drive_type d = PAD_DRIVE;
   wire [4:0]          l = MODE_CMD.line;
   wire [1:0]          m = MODE_WE ? MODE_CMD.mode : 2'h3;
   chk_valid_pulse: assert property (STATUS_RE |=> STATUS_VALID)
      else $error("valid lost");
   chk_valid_idle: assert property (!STATUS_RE |=> !STATUS_VALID)
      else $error("stray valid");
   chk_status_word: assert property ($stable(PAD_IN)[*4] ##0 STATUS_RE |=> STATUS_DATA ==
      ($past(STATUS_SEL) ? $past(PAD_IN[31:16]) : $past(PAD_IN[15:0]))) else $error("bad word");
   chk_out_mode: assert property (m == MODE_OUT |=> d.oe[$past(l)] && !d.pull_up[$past(l)])
      else $error("no drive");
   chk_in_pull: assert property (m == MODE_IN |=> !d.oe[$past(l)] &&
      d.pull_up[$past(l)] == PULL_UP_MAP[$past(l)]) else $error("bad pull");
   chk_alt_pass: assert property (m == MODE_ALT |=> d.oe[$past(l)] == ALT_OE[$past(l)])
      else $error("alt not passed");
   chk_pull_dir: assert property ((d.pull_up & ~PULL_UP_MAP | d.pull_down & PULL_UP_MAP) == 0)
      else $error("pull flipped");
   chk_reset_vals: assert property (disable iff (1'b0) !RST_N |-> d.oe == 32'h0 &&
      d.pull_up == PULL_UP_MAP && !STATUS_VALID) else $error("bad reset");
   cover property (STATUS_RE && STATUS_SEL);
   cover property (m == MODE_ALT);
   cover property (PIN_WE);
endmodule // programmable_io_port_sva
bind programmable_io_port programmable_io_port_sva chk_u (.*);

// ===== verif/programmable_io_port_tb_top.sv
module programmable_io_port_tb_top;
   import pio_port_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // reset starts high so the drop at time zero is a real falling edge
   logic CLK_SYS = 0, RST_N = 1, MODE_WE = 0, PIN_WE = 0, STATUS_RE = 0, STATUS_SEL = 0;
   logic          STATUS_VALID;
   mode_cmd_type  MODE_CMD = '0;
   write_cmd_type PIN_CMD = '0;
   logic [15:0]   STATUS_DATA;
   logic [31:0]   ALT_OUT = '0, ALT_OE = '0, ALT_IN, PAD_IN, xv = '0, xe = '0;
   pad_drive_type PAD_DRIVE;
   int            n_mismatch = 0, n_compared = 0;
   programmable_io_port dut_u (.*);
   pio_pad_model pad_u (.d(PAD_DRIVE), .xv(xv), .xe(xe), .pad(PAD_IN));
   initial forever #25 CLK_SYS = ~CLK_SYS;
   task chk(string n, logic [31:0] e, logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         $display("MISMATCH %s exp %h got %h", n, e, s);
         n_mismatch++;
      end
   endtask
   task mode(logic [4:0] l, logic [1:0] c);
      @(posedge CLK_SYS);
      MODE_WE <= 1'h1;
      MODE_CMD <= '{l, c};
      @(posedge CLK_SYS);
      MODE_WE <= 1'h0;
      @(negedge CLK_SYS);
   endtask
   task pin(logic [4:0] l, logic v);
      @(posedge CLK_SYS);
      PIN_WE <= 1'h1;
      PIN_CMD <= '{l, v};
      @(posedge CLK_SYS);
      PIN_WE <= 1'h0;
      @(negedge CLK_SYS);
   endtask
   // waits out the two-flop pad sync first
   task rd(logic s, logic [15:0] e);
      repeat (3) @(posedge CLK_SYS);
      STATUS_RE <= 1'h1;
      STATUS_SEL <= s;
      @(posedge CLK_SYS);
      STATUS_RE <= 1'h0;
      @(negedge CLK_SYS);
      chk("valid", 32'h1, STATUS_VALID);
      chk("status", e, STATUS_DATA);
   endtask
   task t_reset;
      chk("oe", 32'h0, PAD_DRIVE.oe);
      chk("pull_up", 32'hFFFF_FE1F, PAD_DRIVE.pull_up);
      chk("pull_down", 32'h0000_01E0, PAD_DRIVE.pull_down);
      rd(1'h0, 16'hFE1F);
      rd(1'h1, 16'hFFFF);
   endtask
   task t_out;
      pin(5'h0, 1'h1);
      chk("oe0", 32'h0, PAD_DRIVE.oe);
      mode(5'h0, MODE_OUT);
      chk("out0", 32'h1, PAD_DRIVE.out & PAD_DRIVE.oe);
      pin(5'h0, 1'h0);
      mode(5'h0, 2'h3);
      chk("oe0", 32'h1, PAD_DRIVE.oe);
      rd(1'h0, 16'hFE1E);
      mode(5'h0, MODE_IN);
      rd(1'h0, 16'hFE1F);
   endtask
   task t_alt;
      @(posedge CLK_SYS);
      ALT_OE <= 32'h8000_0000;
      mode(5'h1F, MODE_ALT);
      rd(1'h1, 16'h7FFF);
      chk("alt_in0", 32'h0, ALT_IN);
      @(posedge CLK_SYS);
      ALT_OUT <= 32'h8000_0000;
      rd(1'h1, 16'hFFFF);
      chk("alt_in1", 32'h8000_0000, ALT_IN);
      chk("alt_out", 32'h8000_0000, PAD_DRIVE.out & PAD_DRIVE.oe);
      mode(5'h1F, MODE_IN);
      chk("alt_off", 32'h0, ALT_IN | PAD_DRIVE.oe);
      xe <= 32'h0020_0040;
      xv <= 32'h0000_0040;
      rd(1'h0, 16'hFE5F);
      rd(1'h1, 16'hFFDF);
   endtask
   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      RST_N <= 1'h0;
      repeat (16) @(posedge CLK_SYS);
      RST_N <= 1'h1;
      @(negedge CLK_SYS);
      t_reset();
      t_out();
      t_alt();
      end_of_test();
   end
   initial begin
      #100000;
      n_mismatch++;
      end_of_test();
   end
endmodule // programmable_io_port_tb_top

// ===== verilog/pio_port_pkg.sv
package pio_port_pkg;

   // ----------------------------------------------------------------
   // sizes and codes
   // ----------------------------------------------------------------
   localparam int         LINE_COUNT = 32;
   localparam int         HALF_WIDTH = 16;
   localparam logic [1:0] MODE_ALT   = 2'h0;
   localparam logic [1:0] MODE_IN    = 2'h1;
   localparam logic [1:0] MODE_OUT   = 2'h2;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   // pull-down on lines 5..8, pull-up elsewhere; fixed, never written
   localparam logic [31:0] PULL_UP_MAP    = 32'hFFFF_FE1F;
   localparam logic [1:0]  RESET_MODE     = 2'h1;
   localparam logic [31:0] RESET_OUT_DATA = 32'h0000_0000;
   localparam logic [15:0] RESET_STATUS   = 16'h0000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] line;
      logic [1:0] mode;
   } mode_cmd_type;

   typedef struct packed {
      logic [4:0] line;
      logic       value;
   } write_cmd_type;

   typedef struct packed {
      logic [31:0] out;
      logic [31:0] oe;
      logic [31:0] pull_up;
      logic [31:0] pull_down;
   } pad_drive_type;

endpackage

// ===== verilog/programmable_io_port.sv
module programmable_io_port
   import pio_port_pkg::*;
#(
   parameter int LINES = LINE_COUNT
) (
   input  wire logic          CLK_SYS,
   input  wire logic          RST_N,
   input  wire logic          MODE_WE,
   input  wire mode_cmd_type  MODE_CMD,
   input  wire logic          PIN_WE,
   input  wire write_cmd_type PIN_CMD,
   input  wire logic          STATUS_RE,
   input  wire logic          STATUS_SEL,
   output logic [15:0]        STATUS_DATA,
   output logic               STATUS_VALID,
   input  wire logic [31:0]   ALT_OUT,
   input  wire logic [31:0]   ALT_OE,
   output logic [31:0]        ALT_IN,
   input  wire logic [31:0]   PAD_IN,
   output pad_drive_type      PAD_DRIVE
);

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   if (LINES != LINE_COUNT) begin : g_bad_lines
      $error("LINES must be 32");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [1:0]  mode_r   [LINES];
   logic [1:0]  mode_nxt [LINES];
   logic [31:0] out_r;
   logic [31:0] out_nxt;
   logic [31:0] pad_s1_r;
   logic [31:0] pad_s2_r;
   logic [15:0] status_r;
   logic [15:0] status_nxt;
   logic        valid_r;
   logic        valid_nxt;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < LINES; i++) begin
         mode_nxt[i] = mode_r[i];
      end
      // code 3 is unused; ignored so a line never lands in no mode
      if (MODE_WE && MODE_CMD.mode != 2'h3) begin
         mode_nxt[MODE_CMD.line] = MODE_CMD.mode;
      end
      out_nxt = out_r;
      // latch kept even when not output; only pins in output mode show it
      if (PIN_WE) begin
         out_nxt[PIN_CMD.line] = PIN_CMD.value;
      end
      status_nxt = status_r;
      valid_nxt  = STATUS_RE;
      if (STATUS_RE) begin
         status_nxt = STATUS_SEL ? pad_s2_r[31:16] : pad_s2_r[15:0];
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < LINE_COUNT; i++) begin
            mode_r[i] <= RESET_MODE;
         end
         out_r    <= RESET_OUT_DATA;
         pad_s1_r <= 32'h0000_0000;
         pad_s2_r <= 32'h0000_0000;
         status_r <= RESET_STATUS;
         valid_r  <= 1'b0;
      end else begin
         mode_r   <= mode_nxt;
         out_r    <= out_nxt;
         pad_s1_r <= PAD_IN;
         pad_s2_r <= pad_s1_r;
         status_r <= status_nxt;
         valid_r  <= valid_nxt;
      end
   end

   // ----------------------------------------------------------------
   // per-line pad steering
   // ----------------------------------------------------------------
   for (genvar g = 0; g < LINES; g++) begin : g_line
      always_comb begin
         unique case (mode_r[g])
            MODE_ALT: begin
               PAD_DRIVE.out[g]       = ALT_OUT[g];
               PAD_DRIVE.oe[g]        = ALT_OE[g];
               PAD_DRIVE.pull_up[g]   = 1'b0;
               PAD_DRIVE.pull_down[g] = 1'b0;
            end
            MODE_OUT: begin
               PAD_DRIVE.out[g]       = out_r[g];
               PAD_DRIVE.oe[g]        = 1'b1;
               PAD_DRIVE.pull_up[g]   = 1'b0;
               PAD_DRIVE.pull_down[g] = 1'b0;
            end
            default: begin
               // input mode, and any stray code, is safe undriven input
               PAD_DRIVE.out[g]       = 1'b0;
               PAD_DRIVE.oe[g]        = 1'b0;
               PAD_DRIVE.pull_up[g]   = PULL_UP_MAP[g];
               PAD_DRIVE.pull_down[g] = !PULL_UP_MAP[g];
            end
         endcase
      end
   end

   // peripheral sees the synchronised pad only while its line is alternate
   always_comb begin
      for (int i = 0; i < LINES; i++) begin
         ALT_IN[i] = (mode_r[i] == MODE_ALT) ? pad_s2_r[i] : 1'b0;
      end
   end

   assign STATUS_DATA  = status_r;
   assign STATUS_VALID = valid_r;

endmodule // programmable_io_port
